// ===== logic/gpctl_pkg.sv
// gpctl_pkg: register map, field positions, reset values and trigger modes for
// the per-pin control block. Assumes a 32-bit APB word per register.
package gpctl_pkg;
  localparam logic [11:0] GPCTL_CTRL_OFFS = 12'h060;
  localparam logic [11:0] GPCTL_STAT_OFFS = 12'h064;
  localparam logic [11:0] GPCTL_IMSK_OFFS = 12'h068;
  localparam int GPCTL_FWD_MASK_BIT = 25;
  localparam int GPCTL_TRIG_HI = 23;
  localparam int GPCTL_TRIG_LO = 21;
  localparam int GPCTL_IRQ_EN_BIT = 20;
  localparam int GPCTL_DRV_HI = 14;
  localparam int GPCTL_DRV_LO = 12;
  localparam int GPCTL_PU10K_BIT = 11;
  localparam int GPCTL_PD100K_BIT = 9;
  localparam int GPCTL_PU100K_BIT = 8;
  localparam int GPCTL_STAT_PEND_BIT = 0;
  localparam logic [31:0] GPCTL_CTRL_WMASK = 32'h02F0_7B00;
  localparam logic [2:0] GPCTL_DRV_RST = 3'h1;
  localparam logic [2:0] GPCTL_TRIG_RST = 3'h0;
  localparam logic [2:0] GPCTL_TRIG_RISE = 3'h0;
  localparam logic [2:0] GPCTL_TRIG_FALL = 3'h1;
  localparam logic [2:0] GPCTL_TRIG_BOTH = 3'h2;
  localparam logic [2:0] GPCTL_TRIG_HIGH = 3'h3;
  localparam logic [2:0] GPCTL_TRIG_LOW = 3'h4;
  localparam logic [31:0] GPCTL_CTRL_RST = 32'h0000_1000;
endpackage

// ===== logic/gpctl_evt_if.sv
// gpctl_evt_if: trigger settings and detected event between the register
// file and the pin detector. Assumes one clock domain.
`timescale 1ns/1ps
interface gpctl_evt_if;
  logic [2:0] trig_mode;
  logic trig_event;
  modport ctrl (output trig_mode, input trig_event);
  modport det (input trig_mode, output trig_event);
endinterface

// ===== logic/gpctl_detect.sv
// gpctl_detect: synchronises the pin and flags the selected trigger condition.
// Assumes pin_i may be asynchronous to the system clock.
`timescale 1ns/1ps
module gpctl_detect
  import gpctl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  gpctl_evt_if.det evt
);
  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;

  // two-stage synchroniser, then a history sample for edge compare
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      sync1_ff <= pin_i;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // mode decode; reserved codes never trigger
  always_comb begin
    unique case (evt.trig_mode)
      GPCTL_TRIG_RISE: evt.trig_event = sync2_ff & ~prev_ff;
      GPCTL_TRIG_FALL: evt.trig_event = ~sync2_ff & prev_ff;
      GPCTL_TRIG_BOTH: evt.trig_event = sync2_ff ^ prev_ff;
      GPCTL_TRIG_HIGH: evt.trig_event = sync2_ff;
      GPCTL_TRIG_LOW: evt.trig_event = ~sync2_ff;
      default: evt.trig_event = 1'b0;
    endcase
  end
endmodule

// ===== logic/gpctl_regs.sv
// gpctl_regs: scratch reserve module for read-data muxing of the register file.
// Assumes the raw 12-bit APB address, decoded here.
`timescale 1ns/1ps
module gpctl_regs
  import gpctl_pkg::*;
(
  input wire logic [31:0] ctrl_i,
  input wire logic [31:0] stat_i,
  input wire logic [31:0] imsk_i,
  input wire logic [11:0] addr_i,
  output logic [31:0] rdata_o,
  output logic hit_o
);
  // word select; unmapped addresses read zero and report a miss
  always_comb begin
    hit_o = 1'b1;
    unique case (addr_i)
      GPCTL_CTRL_OFFS: rdata_o = ctrl_i;
      GPCTL_STAT_OFFS: rdata_o = stat_i;
      GPCTL_IMSK_OFFS: rdata_o = imsk_i;
      default: begin
        rdata_o = 32'h0000_0000;
        hit_o = 1'b0;
      end
    endcase
  end
endmodule

// ===== logic/gpctl_top.sv
// gpctl_top: per-pin control register, trigger detection and interrupt
// forwarding for one general-purpose pin, reached over APB.
// Assumes one 200 MHz clock with synchronous active-high reset.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module gpctl_top
  import gpctl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pin_i,
  output logic [2:0] drive_strength_select_o,
  output logic pullup_10k_enable_o,
  output logic pulldown_100k_enable_o,
  output logic pullup_100k_enable_o,
  output logic irq_pending_o,
  output logic interrupt_controller_req_o,
  output logic irq_o
);
  logic [31:0] ctrl_ff;
  logic pend_ff;
  logic imsk_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [31:0] rd_mux;
  logic hit;
  logic acc;
  logic wr;
  logic [31:0] bmask;
  logic pend_set;
  gpctl_evt_if evt ();

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  // single-cycle access phase: ready whenever addressed
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

  // byte-enable expansion for partial writes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bmask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  gpctl_detect u_det (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(pin_i),
    .evt(evt)
  );

  gpctl_regs u_regs (
    .ctrl_i(ctrl_ff),
    .stat_i({31'h0000_0000, pend_ff}),
    .imsk_i({31'h0000_0000, imsk_ff}),
    .addr_i(paddr),
    .rdata_o(rd_mux),
    .hit_o(hit)
  );

  // control register; only documented fields are writable
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_ff <= GPCTL_CTRL_RST;
    end else if (wr && paddr == GPCTL_CTRL_OFFS) begin
      ctrl_ff <= (ctrl_ff & ~(bmask & GPCTL_CTRL_WMASK))
        | (pwdata & bmask & GPCTL_CTRL_WMASK);
    end
  end

  assign evt.trig_mode = ctrl_ff[GPCTL_TRIG_HI:GPCTL_TRIG_LO];
  // pending set only while enabled
  assign pend_set = ctrl_ff[GPCTL_IRQ_EN_BIT] & evt.trig_event;

  // sticky pending, write one to clear; a new event wins over the clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pend_ff <= 1'b0;
    end else if (pend_set) begin
      pend_ff <= 1'b1;
    end else if (wr && paddr == GPCTL_STAT_OFFS && pstrb[0]
                 && pwdata[GPCTL_STAT_PEND_BIT]) begin
      pend_ff <= 1'b0;
    end
  end

  // local interrupt mask for irq_o
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      imsk_ff <= 1'b0;
    end else if (wr && paddr == GPCTL_IMSK_OFFS && pstrb[0]) begin
      imsk_ff <= pwdata[0];
    end
  end

  // read data and error capture at the setup edge, before the access phase
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_ff <= ~hit;
    end
  end

  // pad controls straight from the register
  assign drive_strength_select_o = ctrl_ff[GPCTL_DRV_HI:GPCTL_DRV_LO];
  assign pullup_10k_enable_o = ctrl_ff[GPCTL_PU10K_BIT];
  assign pulldown_100k_enable_o = ctrl_ff[GPCTL_PD100K_BIT];
  assign pullup_100k_enable_o = ctrl_ff[GPCTL_PU100K_BIT];

  // controller request gated by enable and forward mask; irq_o by the local mask
  assign irq_pending_o = pend_ff;
  assign interrupt_controller_req_o = pend_ff & ctrl_ff[GPCTL_FWD_MASK_BIT]
    & ctrl_ff[GPCTL_IRQ_EN_BIT];
  assign irq_o = pend_ff & imsk_ff;
endmodule

// ===== bench/gpctl_assertions.sv
// gpctl_assertions: port-level checks of gpctl_top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module gpctl_chk (
  input wire logic sys_clk_i, rst_i, psel, penable, pwrite, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [2:0] drive_strength_select_o,
  input wire logic pullup_10k_enable_o, pulldown_100k_enable_o, pullup_100k_enable_o,
  input wire logic irq_pending_o, interrupt_controller_req_o, irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic acc;
  logic wc;
  // control-register write at the access edge
  assign acc = psel & penable;
  assign wc = acc & pwrite & (paddr == 12'h060);
  property p_rst;
    $past(rst_i) |-> drive_strength_select_o == 3'h1 && !pullup_10k_enable_o
      && !pulldown_100k_enable_o && !pullup_100k_enable_o && !irq_pending_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_drv;
    wc |=> drive_strength_select_o == $past(pwdata[14:12]);
  endproperty
  a_drv: assert property (p_drv) else $error("drive field wrong");
  property p_pul;
    wc |=> {pullup_10k_enable_o, pulldown_100k_enable_o, pullup_100k_enable_o}
      == {$past(pwdata[11]), $past(pwdata[9]), $past(pwdata[8])};
  endproperty
  a_pul: assert property (p_pul) else $error("pull bits wrong");
  property p_rsv;
    acc && !pwrite && paddr == 12'h060 |-> (prdata & 32'hFD0F8400) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_en;
    wc && !pwdata[20] |=> !interrupt_controller_req_o;
  endproperty
  a_en: assert property (p_en) else $error("request while disabled");
  property p_fwd;
    wc && !pwdata[25] |=> !interrupt_controller_req_o;
  endproperty
  a_fwd: assert property (p_fwd) else $error("request while masked");
  property p_req;
    interrupt_controller_req_o || irq_o |-> irq_pending_o;
  endproperty
  a_req: assert property (p_req) else $error("request without pending");
  property p_stk;
    irq_pending_o && !(acc && pwrite && paddr == 12'h064 && pwdata[0]) |=> irq_pending_o;
  endproperty
  a_stk: assert property (p_stk) else $error("pending lost");
  property p_err;
    acc && !(paddr inside {12'h060, 12'h064, 12'h068}) |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no error on unmapped");
  c_wr: cover property (wc);
  c_req: cover property ($rose(interrupt_controller_req_o));
  c_irq: cover property ($rose(irq_o));
endmodule
bind gpctl_top gpctl_chk gpctl_chk_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .drive_strength_select_o(drive_strength_select_o),
  .pullup_10k_enable_o(pullup_10k_enable_o), .pulldown_100k_enable_o(pulldown_100k_enable_o),
  .pullup_100k_enable_o(pullup_100k_enable_o), .irq_pending_o(irq_pending_o),
  .interrupt_controller_req_o(interrupt_controller_req_o), .irq_o(irq_o));

// ===== bench/gpctl_pin_model.sv
// gpctl_pin_model: off-chip source driving the pin.
// Assumes level requests change at the rising clock edge.
`timescale 1ns/1ps
module gpctl_pin_model (
  input wire logic sys_clk_i,
  input wire logic lvl_i,
  output logic pin_o
);
  // pin follows the request one edge later
  always_ff @(posedge sys_clk_i) begin
    pin_o <= lvl_i;
  end
endmodule

// ===== bench/gpio_pin_control_irq_bench.sv
// gpio_pin_control_irq_bench: self-checking bench for gpctl_top.
// Assumes zero-wait APB and a 200 MHz clock.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module gpio_pin_control_irq_bench;
  import gpctl_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, lvl = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, d;
  logic [32:0] ex;
  logic [2:0] drv, m;
  logic pready, pslverr, pin, pu10, pd, pu100, pend, req, irq;
  logic [32:0] expq[$];
  int n_mismatch = 0, check_count = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  gpctl_pin_model gpctl_pin_model_inst (.sys_clk_i(sys_clk_i), .lvl_i(lvl), .pin_o(pin));
  gpctl_top gpctl_top_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin),
    .drive_strength_select_o(drv), .pullup_10k_enable_o(pu10), .pulldown_100k_enable_o(pd),
    .pullup_100k_enable_o(pu100), .irq_pending_o(pend), .interrupt_controller_req_o(req),
    .irq_o(irq));
  // one apb transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk_i) begin psel <= 1; pwrite <= w; paddr <= a; pwdata <= v; end
    @(posedge sys_clk_i) penable <= 1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back({!(a inside {GPCTL_CTRL_OFFS, GPCTL_STAT_OFFS, GPCTL_IMSK_OFFS}), e});
    apb(0, a, 32'h0);
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // monitor: each read answer against the oldest note
  always @(posedge sys_clk_i) if (psel && penable && pready && !pwrite) begin
    ex = expq.pop_front();
    `CHK({pslverr, prdata}, ex)
  end
  initial begin #50000; n_mismatch++; report_and_stop; end
  initial begin
    void'($urandom(32'hE9BC));
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 0;
    rd(GPCTL_CTRL_OFFS, GPCTL_CTRL_RST);
    rd(12'h06C, 32'h0);
    // random pad settings with the enable kept off
    repeat (4) begin
      d = $urandom & ~32'h0010_0000;
      apb(1, GPCTL_CTRL_OFFS, d);
      #1 `CHK({drv, pu10, pd, pu100}, {d[14:12], d[11], d[9], d[8]})
      rd(GPCTL_CTRL_OFFS, d & GPCTL_CTRL_WMASK);
    end
    // every trigger code, one reserved code, then enable off
    for (int i = 0; i < 7; i++) begin
      m = (i == 6) ? 3'h0 : 3'(i);
      lvl <= !(m == 3'h0 || m == 3'h3);
      repeat (5) @(posedge sys_clk_i);
      apb(1, GPCTL_CTRL_OFFS, {6'h0, i[0], 1'b0, m, i != 6, 20'h0});
      apb(1, GPCTL_IMSK_OFFS, {31'h0, i[1]});
      apb(1, GPCTL_STAT_OFFS, 32'h1);
      lvl <= ~lvl;
      repeat (6) @(posedge sys_clk_i);
      #1 `CHK({pend, req, irq}, {i < 5, i < 5 && i[0], i < 5 && i[1]})
      rd(GPCTL_STAT_OFFS, {31'h0, i < 5});
      rd(GPCTL_IMSK_OFFS, {31'h0, i[1]});
    end
    // mid-run reset brings the control word back to its reset value
    rst_i <= 1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 0;
    rd(GPCTL_CTRL_OFFS, GPCTL_CTRL_RST);
    report_and_stop;
  end
endmodule
